// ===== branch_trace_capture.sv
// Branch trace capture: on-chip ring buffer, trace port streamer, debugger address translation.
// Assumes branch events and trace port connect/ready are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
`include "branch_trace_regs.svh"
module branch_trace_capture
   import branch_trace_pkg::*;
#(
   parameter int AW = `TRC_ADDR_W,
   parameter int FIFO_DEPTH = `TRC_FIFO_DEPTH,
   parameter int ONCHIP_DEPTH = `TRC_ONCHIP_DEPTH,
   parameter int TLB_N = `TRC_TLB_ENTRIES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Configuration
   input wire logic port_trace_sel,
   input wire logic realtime_mode,
   input wire logic port_connected,
   // Branch events from the CPU
   input wire logic branch_valid,
   input wire logic [AW-1:0] branch_src,
   input wire logic [AW-1:0] branch_dst,
   output logic cpu_stall,
   // On-chip buffer readout
   input wire logic [$clog2(ONCHIP_DEPTH)-1:0] onchip_rd_idx,
   output logic [2*AW-1:0] onchip_rd_data,
   output logic [$clog2(ONCHIP_DEPTH)-1:0] onchip_wr_ptr,
   output logic onchip_wrapped,
   // Debug trace port
   output logic [3:0] debug_trace_port,
   output logic trace_sync,
   input wire logic port_ready,
   output logic record_lost,
   // TLB load port
   input wire logic tlb_we,
   input wire logic [$clog2(TLB_N)-1:0] tlb_idx,
   input wire logic tlb_valid_in,
   input wire logic [AW-`TRC_PAGE_BITS-1:0] tlb_vpn_in,
   input wire logic [AW-`TRC_PAGE_BITS-1:0] tlb_ppn_in,
   // Debugger memory access
   input wire logic mmu_enable,
   input wire logic dbg_req,
   input wire logic [AW-1:0] dbg_addr,
   output logic dbg_ack,
   output logic [AW-1:0] dbg_phys_addr,
   output logic tlb_miss
);
   localparam int OW = $clog2(ONCHIP_DEPTH);
   localparam int RW = 2 * AW;
   localparam int PB = `TRC_PAGE_BITS;
   localparam int VW = AW - PB;
   localparam logic [4:0] LAST_NIB = 5'(`TRC_NIBBLE_COUNT - 1);

   // ----------------------------------------------------------------
   // Record capture
   // ----------------------------------------------------------------
   logic [RW-1:0] record;
   logic port_active;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [RW-1:0] fifo_out_data;
   logic fifo_flush;
   assign record = {branch_src, branch_dst};
   assign port_active = port_trace_sel && port_connected;

   // ----------------------------------------------------------------
   // On-chip ring buffer
   // ----------------------------------------------------------------
   logic [RW-1:0] ring_r [ONCHIP_DEPTH];
   logic [OW-1:0] ring_wr_r;
   logic ring_wrap_r;
   logic ring_we;
   assign ring_we = branch_valid && !port_trace_sel;
   always_ff @(posedge mclk) begin
      if (ring_we) begin
         ring_r[ring_wr_r] <= record;
      end
   end
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         ring_wr_r <= '0;
         ring_wrap_r <= 1'b0;
      end else if (ring_we) begin
         ring_wr_r <= (ring_wr_r == OW'(ONCHIP_DEPTH - 1)) ? '0 : ring_wr_r + 1'b1;
         if (ring_wr_r == OW'(ONCHIP_DEPTH - 1)) begin
            ring_wrap_r <= 1'b1;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         onchip_rd_data <= '0;
      end else begin
         onchip_rd_data <= ring_r[onchip_rd_idx];
      end
   end
   assign onchip_wr_ptr = ring_wr_r;
   assign onchip_wrapped = ring_wrap_r;

   // ----------------------------------------------------------------
   // Trace port path: FIFO then nibble serialiser
   // ----------------------------------------------------------------
   logic fifo_push;
   // realtime flushes queue on new branch while busy
   assign fifo_push = branch_valid && port_active;
   // outside realtime mode, stall while the queue is full
   assign cpu_stall = port_active && !realtime_mode && branch_valid && !fifo_in_ready;

   port_state_e state_r;
   logic [RW-1:0] shift_r;
   logic [4:0] nib_r;
   logic busy;
   assign busy = (state_r != PORT_IDLE) || fifo_out_valid;
   assign fifo_flush = realtime_mode && fifo_push && busy;

   trace_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk(mclk),
      .resetn(resetn),
      .flush(fifo_flush),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(record),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );
   assign fifo_out_ready = (state_r == PORT_IDLE) && port_active && !fifo_flush;

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_r <= PORT_IDLE;
         shift_r <= '0;
         nib_r <= '0;
      end else if (!port_active || fifo_flush) begin
         if (fifo_flush) begin
            state_r <= PORT_LOAD;
            shift_r <= record;
            nib_r <= '0;
         end else begin
            state_r <= PORT_IDLE;
         end
      end else begin
         case (state_r)
            PORT_IDLE: begin
               if (fifo_out_valid) begin
                  state_r <= PORT_LOAD;
                  shift_r <= fifo_out_data;
                  nib_r <= '0;
               end
            end
            PORT_LOAD: begin
               state_r <= PORT_SEND;
            end
            PORT_SEND: begin
               if (port_ready) begin
                  shift_r <= {shift_r[RW-5:0], 4'h0};
                  if (nib_r == LAST_NIB) begin
                     state_r <= PORT_IDLE;
                  end else begin
                     nib_r <= nib_r + 1'b1;
                  end
               end
            end
            default: state_r <= PORT_IDLE;
         endcase
      end
   end
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         debug_trace_port <= 4'h0;
         trace_sync <= 1'b0;
      end else begin
         debug_trace_port <= (port_active && state_r == PORT_SEND) ? shift_r[RW-1:RW-4] : 4'h0;
         trace_sync <= port_active && state_r == PORT_SEND && nib_r == 5'h0_0;
      end
   end
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         record_lost <= 1'b0;
      end else begin
         record_lost <= fifo_flush;
      end
   end

   // ----------------------------------------------------------------
   // TLB and debugger translation
   // ----------------------------------------------------------------
   logic [TLB_N-1:0] tlb_v_r;
   logic [VW-1:0] tlb_vpn_r [TLB_N];
   logic [VW-1:0] tlb_ppn_r [TLB_N];
   logic [TLB_N-1:0] hit;
   logic [VW-1:0] hit_ppn;
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         tlb_v_r <= '0;
      end else if (tlb_we) begin
         tlb_v_r[tlb_idx] <= tlb_valid_in;
      end
   end
   always_ff @(posedge mclk) begin
      if (tlb_we) begin
         tlb_vpn_r[tlb_idx] <= tlb_vpn_in;
         tlb_ppn_r[tlb_idx] <= tlb_ppn_in;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < TLB_N; gi++) begin : g_tlb
         assign hit[gi] = tlb_v_r[gi] && (tlb_vpn_r[gi] == dbg_addr[AW-1:PB]);
      end
   endgenerate
   always_comb begin
      hit_ppn = '0;
      for (int i = 0; i < TLB_N; i++) begin
         if (hit[i]) begin
            hit_ppn = tlb_ppn_r[i];
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         dbg_ack <= 1'b0;
         dbg_phys_addr <= '0;
         tlb_miss <= 1'b0;
      end else begin
         dbg_ack <= dbg_req && !(mmu_enable && hit == '0);
         tlb_miss <= dbg_req && mmu_enable && hit == '0;
         if (dbg_req) begin
            dbg_phys_addr <= mmu_enable ? {hit_ppn, dbg_addr[PB-1:0]} : dbg_addr;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_flush;
      fifo_flush;
   endsequence
   // A further branch may abort again while still loading, so the restart is checked one step at a time
   sequence s_restart;
      state_r == PORT_LOAD && shift_r == $past(record);
   endsequence
   sequence s_load_done;
      state_r == PORT_LOAD && port_active && !fifo_flush;
   endsequence
   AST_ONCHIP_PTR: assert property (@(posedge mclk) disable iff (!resetn)
      ring_we |=> ring_wr_r == (($past(ring_wr_r) == OW'(ONCHIP_DEPTH - 1)) ? '0 : $past(ring_wr_r) + 1'b1))
      else $error("on-chip pointer did not advance");
   AST_NO_STALL_ONCHIP: assert property (@(posedge mclk) disable iff (!resetn)
      !port_trace_sel |-> !cpu_stall)
      else $error("stall in on-chip mode");
   AST_NO_STALL_RT: assert property (@(posedge mclk) disable iff (!resetn)
      realtime_mode |-> !cpu_stall)
      else $error("stall in realtime mode");
   AST_ABORT: assert property (@(posedge mclk) disable iff (!resetn)
      s_flush |=> s_restart)
      else $error("abort did not restart output");
   AST_LOAD_SEND: assert property (@(posedge mclk) disable iff (!resetn)
      s_load_done |=> state_r == PORT_SEND)
      else $error("loaded record not sent");
   AST_STALL_NRT: assert property (@(posedge mclk) disable iff (!resetn)
      port_active && !realtime_mode && branch_valid && !fifo_in_ready |-> cpu_stall)
      else $error("missing stall on full queue");
   AST_PORT_QUIET: assert property (@(posedge mclk) disable iff (!resetn)
      !port_active |=> debug_trace_port == 4'h0 && !trace_sync)
      else $error("port driven while disconnected");
   AST_MISS: assert property (@(posedge mclk) disable iff (!resetn)
      dbg_req && mmu_enable && hit == '0 |=> tlb_miss && !dbg_ack)
      else $error("miss not flagged");
   AST_XLATE: assert property (@(posedge mclk) disable iff (!resetn)
      dbg_req && mmu_enable && hit != '0 |=> dbg_ack && dbg_phys_addr[AW-1:PB] == $past(hit_ppn))
      else $error("wrong translated address");
   AST_RECORD: assert property (@(posedge mclk) disable iff (!resetn)
      ring_we |=> ring_r[$past(ring_wr_r)] == $past(record))
      else $error("record not captured");
endmodule
`default_nettype wire

// ===== branch_trace_regs.svh
// Constants for the branch trace capture block.
// Assumes inclusion by bare name from design files.
`ifndef BRANCH_TRACE_REGS_SVH
`define BRANCH_TRACE_REGS_SVH
`define TRC_ADDR_W 32
`define TRC_FIFO_DEPTH 32
`define TRC_ONCHIP_DEPTH 16
`define TRC_NIBBLE_COUNT 16
`define TRC_TLB_ENTRIES 4
`define TRC_PAGE_BITS 12
`endif

// ===== branch_trace_pkg.sv
// Types for the branch trace capture block.
// Assumes no surroundings.
package branch_trace_pkg;
   typedef enum logic [1:0] {
      PORT_IDLE = 2'b00,
      PORT_LOAD = 2'b01,
      PORT_SEND = 2'b11
   } port_state_e;
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_VIRTUAL = 2'b01,
      MODE_PHYSICAL = 2'b10
   } area_mode_e;
endpackage

// ===== trace_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock mclk and synchronous active low reset.
`timescale 1ns/1ps
`default_nettype none
module trace_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Flush
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   assign in_ready = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end
   always_ff @(posedge mclk) begin
      if (!resetn || flush) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   AST_NO_OVER: assert property (@(posedge mclk) disable iff (!resetn) cnt_r <= DEPTH)
      else $error("fifo count above depth");
endmodule
`default_nettype wire

// ===== emulator_probe.sv
// Emulator probe model: rebuilds records from the trace port nibbles.
// Assumes MSB-first nibbles with sync on the first, all on mclk.
`timescale 1ns/1ps
`default_nettype none
module emulator_probe #(
   parameter int STORE_N = 4096,
   parameter logic [31:0] MAP_FIRST = 32'h0001_0000,
   parameter logic [31:0] MAP_LAST = 32'h0001_0FFF,
   parameter logic [31:0] MAP_PHYS = 32'h0400_0000
) (
   // Clock
   input wire logic mclk,
   // Trace port
   input wire logic connected,
   input wire logic [3:0] nibble,
   input wire logic sync,
   output logic ready,
   // Control
   input wire logic hold,
   input wire logic slow,
   input wire logic wrap,
   // Emulator address map
   input wire logic map_on,
   input wire logic [31:0] map_va,
   output logic [31:0] map_pa,
   output logic map_hit,
   // Results
   output logic [63:0] last_rec,
   output int rec_count
);
   logic [63:0] acc = '0;
   logic [63:0] store [STORE_N];
   int cnt = 0;
   int fill = 0;
   int wr = 0;
   initial last_rec = '0;
   initial rec_count = 0;
   logic ready_d = 1'b0;
   initial ready = 1'b0;
   // map ahead of TLB, none when off
   assign map_hit = map_on && map_va >= MAP_FIRST && map_va <= MAP_LAST;
   assign map_pa = map_hit ? MAP_PHYS + (map_va - MAP_FIRST) : map_va;
   // listen only attached
   // The block advances on the ready it saw one edge back, so that nibble is taken one edge later
   always @(posedge mclk) begin
      ready <= connected && !hold && !(slow && ready);
      ready_d <= ready;
      if (connected && ready_d) begin
         if (sync) begin
            acc = 64'(nibble);
            cnt = 1;
         end else if (cnt != 0) begin
            acc = {acc[59:0], nibble};
            cnt = cnt + 1;
         end
         if (cnt == 16) begin
            cnt = 0;
            last_rec <= acc;
            rec_count <= rec_count + 1;
            if (wrap || fill < STORE_N) begin
               store[wr] <= acc;
               wr = (wr + 1) % STORE_N;
               fill = (fill < STORE_N) ? fill + 1 : fill;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== branch_trace_capture_test.sv
// Testbench for branch_trace_capture with the emulator probe model.
// Assumes design, package, header and probe are compiled first.
`timescale 1ns/1ps
`default_nettype none
module branch_trace_capture_test;
   import branch_trace_pkg::*;
   logic mclk = 1'b0, resetn = 1'b0, port_trace_sel = 1'b0, realtime_mode = 1'b0;
   logic port_connected = 1'b0, branch_valid = 1'b0, tlb_we = 1'b0, tlb_valid_in = 1'b0;
   logic mmu_enable = 1'b0, dbg_req = 1'b0, hold = 1'b0, slow = 1'b0;
   logic [31:0] branch_src = '0, branch_dst = '0, dbg_addr = '0, dbg_phys_addr, got_addr, e;
   logic [19:0] tlb_vpn_in = '0, tlb_ppn_in = '0;
   logic [3:0] onchip_rd_idx = '0, onchip_wr_ptr, debug_trace_port;
   logic [1:0] tlb_idx = '0;
   logic [63:0] onchip_rd_data, last_rec;
   logic cpu_stall, onchip_wrapped, trace_sync, port_ready, record_lost, dbg_ack, tlb_miss;
   logic got_ack, got_miss, bad, stall_seen = 1'b0, lost_seen = 1'b0;
   logic map_on = 1'b0, map_hit;
   logic [31:0] map_va = '0, map_pa;
   int rec_count, base, fail_count = 0, n_tests = 0, cycles = 0;
   branch_trace_capture dut (.mclk, .resetn, .port_trace_sel, .realtime_mode, .port_connected,
      .branch_valid, .branch_src, .branch_dst, .cpu_stall, .onchip_rd_idx, .onchip_rd_data,
      .onchip_wr_ptr, .onchip_wrapped, .debug_trace_port, .trace_sync, .port_ready, .record_lost,
      .tlb_we, .tlb_idx, .tlb_valid_in, .tlb_vpn_in, .tlb_ppn_in, .mmu_enable, .dbg_req, .dbg_addr,
      .dbg_ack, .dbg_phys_addr, .tlb_miss);
   emulator_probe probe (.mclk, .connected(port_connected), .nibble(debug_trace_port),
      .sync(trace_sync), .ready(port_ready), .hold, .slow, .wrap(1'b1), .map_on, .map_va, .map_pa,
      .map_hit, .last_rec, .rec_count);
   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cpu_stall === 1'b1)
         stall_seen <= 1'b1;
      if (record_lost === 1'b1)
         lost_seen <= 1'b1;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   //------------------------------------------------
   // Tasks
   //------------------------------------------------
   task automatic check_flag(input logic got, input logic exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %b exp %b", $time, msg, got, exp);
      end
   endtask
   task automatic check_word(input logic [63:0] got, input logic [63:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // Holds the branch until the stall drops
   task automatic branch(input logic [31:0] src, input logic [31:0] dst);
      int n;
      n = 0;
      branch_valid <= 1'b1;
      branch_src <= src;
      branch_dst <= dst;
      @(posedge mclk);
      while (cpu_stall !== 1'b0 && n < 200) begin
         n++;
         @(posedge mclk);
      end
   endtask
   task automatic wait_rec(input int target);
      int n;
      n = 0;
      while (rec_count < target && n < 3000) begin
         n++;
         @(posedge mclk);
      end
   endtask
   task automatic dbg(input logic [31:0] a);
      int n;
      n = 0;
      got_ack = 1'b0;
      got_miss = 1'b0;
      dbg_req <= 1'b1;
      dbg_addr <= a;
      @(posedge mclk);
      dbg_req <= 1'b0;
      while (!(got_ack || got_miss) && n < 4) begin
         n++;
         @(posedge mclk);
         got_ack = (dbg_ack === 1'b1);
         got_miss = (tlb_miss === 1'b1);
         got_addr = dbg_phys_addr;
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   //------------------------------------------------
   // Tests
   //------------------------------------------------
   initial begin
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      check_word(64'({cpu_stall, debug_trace_port, dbg_ack, onchip_wr_ptr}), 64'h0, "reset");
      for (int i = 1; i <= 17; i++)
         branch(32'h1000_0000 + 32'(i), 32'h2000_0000 + 32'(i));
      branch_valid <= 1'b0;
      @(posedge mclk);
      check_flag(stall_seen, 1'b0, "onchip stall");
      check_word(64'(onchip_wr_ptr), 64'h1, "wr ptr");
      check_flag(onchip_wrapped, 1'b1, "wrapped");
      for (int k = 0; k < 2; k++) begin
         e = (k == 0) ? 32'd17 : 32'd2;
         onchip_rd_idx <= 4'(k);
         repeat (2) @(posedge mclk);
         check_word(onchip_rd_data, {32'h1000_0000 + e, 32'h2000_0000 + e}, "onchip");
      end
      $display("onchip test done");
      port_trace_sel <= 1'b1;
      branch(32'h0000_00AA, 32'h0000_00BB);
      branch_valid <= 1'b0;
      bad = 1'b0;
      repeat (40) begin
         @(posedge mclk);
         if (debug_trace_port !== 4'h0 || trace_sync !== 1'b0)
            bad = 1'b1;
      end
      check_flag(bad, 1'b0, "port quiet");
      port_connected <= 1'b1;
      slow <= 1'b1;
      @(posedge mclk);
      branch(32'h1234_5678, 32'h9ABC_DEF0);
      branch_valid <= 1'b0;
      wait_rec(1);
      check_word(last_rec, 64'h1234_5678_9ABC_DEF0, "port record");
      check_word(64'(rec_count), 64'h1, "unconnected dropped");
      stall_seen = 1'b0;
      for (int i = 1; i <= 40; i++)
         branch(32'h3000_0000 + 32'(i), 32'h4000_0000 + 32'(i));
      branch_valid <= 1'b0;
      wait_rec(41);
      check_flag(stall_seen, 1'b1, "stall");
      check_word(64'(rec_count), 64'd41, "no loss");
      check_word(last_rec, 64'h3000_0028_4000_0028, "last");
      check_flag(lost_seen, 1'b0, "lost flag");
      $display("port test done");
      realtime_mode <= 1'b1;
      slow <= 1'b0;
      stall_seen = 1'b0;
      base = rec_count;
      branch(32'h5000_0001, 32'h6000_0001);
      branch_valid <= 1'b0;
      repeat (6) @(posedge mclk);
      branch(32'h5000_0002, 32'h6000_0002);
      branch_valid <= 1'b0;
      wait_rec(base + 1);
      repeat (40) @(posedge mclk);
      check_flag(lost_seen, 1'b1, "abort");
      check_word(64'(rec_count - base), 64'h1, "one record");
      check_word(last_rec, 64'h5000_0002_6000_0002, "new record");
      hold <= 1'b1;
      for (int i = 0; i < 40; i++)
         branch(32'(i), 32'(i));
      branch_valid <= 1'b0;
      hold <= 1'b0;
      check_flag(stall_seen, 1'b0, "no stall");
      $display("realtime test done");
      tlb_we <= 1'b1;
      tlb_idx <= 2'd1;
      tlb_valid_in <= 1'b1;
      tlb_vpn_in <= 20'h1_2345;
      tlb_ppn_in <= 20'h0_ABCD;
      mmu_enable <= 1'b1;
      @(posedge mclk);
      tlb_we <= 1'b0;
      @(posedge mclk);
      dbg(32'h1234_5678);
      check_flag(got_ack, 1'b1, "hit");
      check_word(64'(got_addr), 64'h0ABC_D678, "translated");
      dbg(32'h5555_5000);
      check_flag(got_miss, 1'b1, "miss");
      mmu_enable <= 1'b0;
      dbg(32'h5555_5000);
      check_word(64'(got_addr), 64'h5555_5000, "untranslated");
      map_on <= 1'b1;
      map_va <= 32'h0001_0678;
      @(posedge mclk);
      mmu_enable <= !map_hit;
      dbg(map_pa);
      check_word(64'(got_addr), 64'h0400_0678, "map first");
      map_on <= 1'b0;
      map_va <= 32'h1234_5678;
      @(posedge mclk);
      mmu_enable <= !map_hit;
      dbg(map_pa);
      check_word(64'(got_addr), 64'h0ABC_D678, "map off");
      $display("translation test done");
      stop_test();
   end
endmodule
`default_nettype wire
